/* File: dv/cfu_exec_model.sv */
// execution unit model that feeds results into the flag stage
`timescale 1ns/100ps
module cfu_exec_model (
  input wire logic clk,
  output cfu_pkg::cfu_res_s res
);
  import cfu_pkg::*;
  // ----------------------------------------------------------------
  // result launch, one cycle per result, driven at the falling edge
  // ----------------------------------------------------------------
  initial begin
    res = '0;
    res.op = OP_NONE;
  end
  task automatic issue(input cfu_res_s r);
    @(negedge clk);
    res <= r;
  endtask
  // idle lines are not left at the last word, so a stale value cannot pass
  task automatic idle();
    @(negedge clk);
    res.valid <= 1'b0;
    res.word <= ~res.word;
  endtask
endmodule

/* File: dv/test_cfu_flag_update.sv */
// self-checking bench for the condition flag update block
`timescale 1ns/100ps
module test_cfu_flag_update;
  import cfu_pkg::*;
  typedef struct packed {
    cfu_res_s r;
    logic sat;
    cfu_flags_s f;
    logic [RES_W-1:0] d;
  } cfu_row_s;
  logic clk;
  logic srst;
  logic saturate_select;
  cfu_res_s res;
  cfu_flags_s condition_word;
  logic dst_we;
  logic [DST_W-1:0] dst_idx;
  logic [RES_W-1:0] dst_data;
  int err_count;
  int checks;
  int cycles;
  cfu_row_s rows [14];
  cfu_row_s tail_row;
  // ----------------------------------------------------------------
  // instances and clock
  // ----------------------------------------------------------------
  cfu_exec_model cfu_exec_model_inst (.clk(clk), .res(res));
  cfu_flag_update cfu_flag_update_inst (.clk(clk), .srst(srst), .res(res),
    .saturate_select(saturate_select), .condition_word(condition_word),
    .dst_we(dst_we), .dst_idx(dst_idx), .dst_data(dst_data));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ev packs {uf, ov, carry, neg, shift_out, shift_zero}
  function automatic cfu_row_s mk(cfu_op_e op, logic [DST_W-1:0] dst,
    logic [RES_W-1:0] w, logic [5:0] ev, logic sat, logic [6:0] f,
    logic [RES_W-1:0] d);
    mk.r = {1'b1, dst, op, w, ev};
    mk.sat = sat;
    mk.f = f;
    mk.d = d;
  endfunction
  task automatic check(input logic [RES_W-1:0] seen,
    input logic [RES_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a hang ends the run through the same report
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    saturate_select = 1'b0;
    err_count = 0;
    checks = 0;
    cycles = 0;
    rows[0] = mk(OP_INT, 5'h03, 32'h0, 6'h08, 1'b0, 7'h05, 32'h0);
    rows[1] = mk(OP_INT, 5'h07, 32'h5, 6'h14, 1'b1, 7'h2a, SAT_NEG);
    rows[2] = mk(OP_INT, 5'h01, 32'h7fff_0000, 6'h10, 1'b1, 7'h22, SAT_POS);
    rows[3] = mk(OP_INT, 5'h01, 32'h7fff_0000, 6'h10, 1'b0, 7'h22,
      32'h7fff_0000);
    rows[4] = mk(OP_FLT, 5'h02, 32'h1, 6'h20, 1'b1, 7'h70, 32'h1);
    rows[5] = mk(OP_FLT, 5'h04, 32'ha, 6'h0c, 1'b0, 7'h69, 32'ha);
    rows[6] = mk(OP_LOGIC, 5'h05, SAT_NEG, 6'h00, 1'b0, 7'h68, SAT_NEG);
    rows[7] = mk(OP_LOGIC, 5'h06, 32'h0, 6'h04, 1'b0, 7'h64, 32'h0);
    rows[8] = mk(OP_SHIFT, 5'h00, 32'h4000_0000, 6'h02, 1'b0, 7'h61,
      32'h4000_0000);
    rows[9] = mk(OP_SHIFT, 5'h00, 32'h0, 6'h0b, 1'b0, 7'h64, 32'h0);
    rows[10] = mk(OP_INT, 5'h03, 32'h1, 6'h08, 1'b0, 7'h61, 32'h1);
    rows[11] = mk(OP_ABSF, 5'h07, 32'h0, 6'h24, 1'b0, 7'h65, 32'h0);
    rows[12] = mk(OP_INT, 5'h08, 32'h0, 6'h00, 1'b0, 7'h65, 32'h0);
    rows[13] = mk(OP_NONE, 5'h02, 32'h0, 6'h00, 1'b0, 7'h65, 32'h0);
    tail_row = mk(OP_ABSF, 5'h07, 32'h5, 6'h24, 1'b0, 7'h01, 32'h5);
    repeat (20) @(negedge clk);
    check(condition_word, FLAGS_RST);
    check({dst_we, dst_idx}, '0);
    srst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      cfu_exec_model_inst.issue(rows[i].r);
      saturate_select <= rows[i].sat;
      cfu_exec_model_inst.idle();
      check(condition_word, rows[i].f);
      check(condition_word.sticky_underflow, rows[i].f.sticky_underflow);
      check(condition_word.lv, rows[i].f.lv);
      check(condition_word.uf, rows[i].f.uf);
      check(condition_word.n, rows[i].f.n);
      check(condition_word.z, rows[i].f.z);
      check(condition_word.v, rows[i].f.v);
      check(condition_word.c, rows[i].f.c);
      check(dst_data, rows[i].d);
      check({dst_we, dst_idx}, {1'b1, rows[i].r.dst});
    end
    @(negedge clk);
    check(dst_we, 1'b0);
    // second reset in mid-run, then back-to-back results
    srst <= 1'b1;
    @(negedge clk);
    check(condition_word, FLAGS_RST);
    check({dst_we, dst_idx}, '0);
    check(dst_data, WORD_ZERO);
    srst <= 1'b0;
    cfu_exec_model_inst.issue(rows[0].r);
    cfu_exec_model_inst.issue(tail_row.r);
    check({condition_word, dst_we, dst_idx}, {7'h05, 1'b1, 5'h03});
    cfu_exec_model_inst.idle();
    check(condition_word, 7'h01);
    check({dst_idx, dst_data}, {5'h07, 32'h5});
    final_report();
  end
endmodule

/* File: src/cfu_flag_update.sv */
// condition flag update: status flags and destination write stage
`timescale 1ns/100ps

module cfu_flag_update #(
  parameter int NUM_EXT = cfu_pkg::NUM_EXT
) (
  input wire logic clk,
  input wire logic srst,
  input wire cfu_pkg::cfu_res_s res,
  input wire logic saturate_select,
  output cfu_pkg::cfu_flags_s condition_word,
  output logic dst_we,
  output logic [cfu_pkg::DST_W-1:0] dst_idx,
  output logic [cfu_pkg::RES_W-1:0] dst_data
);
  import cfu_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_EXT < 1 || NUM_EXT > (1 << DST_W)) begin : g_bad_ext
    $error("NUM_EXT out of range for the destination index");
  end

  // ----------------------------------------------------------------
  // result decode
  // ----------------------------------------------------------------
  wire is_int;
  wire is_flt;
  wire is_logic;
  wire is_shift;
  wire is_absf;
  wire is_arith;
  wire is_bitwise;
  wire dst_ext;
  wire upd;
  wire word_zero;
  wire sat_hit;

  assign is_int = (res.op == OP_INT);
  assign is_flt = (res.op == OP_FLT);
  assign is_logic = (res.op == OP_LOGIC);
  assign is_shift = (res.op == OP_SHIFT);
  assign is_absf = (res.op == OP_ABSF);
  assign is_arith = is_int | is_flt;
  assign is_bitwise = is_logic | is_shift;
  // dst compared as a wide number so any NUM_EXT up to the index range fits
  assign dst_ext = (int'(res.dst) < NUM_EXT);
  // a result that carries no flag class never touches the word
  assign upd = res.valid & ~(res.op == OP_NONE) & dst_ext;
  assign word_zero = (res.word == WORD_ZERO);
  // only integer overflow clamps; floating overflow has its own result
  assign sat_hit = saturate_select & is_int & res.ov_ev;

  // ----------------------------------------------------------------
  // next flag values
  // ----------------------------------------------------------------
  wire next_luf;
  wire next_lv;
  wire next_uf;
  wire next_n;
  wire next_z;
  wire next_v;
  wire next_c;
  wire arith_n;
  wire shift_c;
  cfu_flags_s next_flags;

  // absf cannot underflow, so the sticky bit just holds there
  assign next_luf = condition_word.sticky_underflow |
                    (res.uf_ev & ~is_absf);
  assign next_lv = condition_word.lv | res.ov_ev;
  assign next_uf = res.uf_ev & ~is_absf;
  assign arith_n = is_arith & res.neg;
  assign next_n = is_bitwise ? res.word[MSB] : arith_n;
  assign next_z = word_zero;
  assign next_v = res.ov_ev;
  assign shift_c = res.shift_zero ? 1'b0 : res.shift_out;
  assign next_c = is_absf ? condition_word.c :
                  is_shift ? shift_c : res.carry;

  assign next_flags = '{sticky_underflow: next_luf, lv: next_lv, uf: next_uf,
                        n: next_n, z: next_z, v: next_v, c: next_c};

  // ----------------------------------------------------------------
  // destination value
  // ----------------------------------------------------------------
  // neg gives the sign of the exact result, so it picks the clamp end
  wire [RES_W-1:0] sat_word;
  wire [RES_W-1:0] next_data;

  assign sat_word = res.neg ? SAT_NEG : SAT_POS;
  assign next_data = sat_hit ? sat_word : res.word;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // flags and write share one edge, so a reader never sees them split
  always_ff @(posedge clk) begin
    if (srst) begin
      condition_word <= FLAGS_RST;
    end else if (upd) begin
      condition_word <= next_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dst_we <= 1'b0;
      dst_idx <= '0;
      dst_data <= WORD_ZERO;
    end else begin
      dst_we <= res.valid;
      dst_idx <= res.dst;
      dst_data <= next_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_luf_sticky: assert property (
    upd && res.uf_ev && !is_absf |=> condition_word.sticky_underflow)
    else $error("sticky underflow not set by underflow");

  a_lv_sticky_hold: assert property (
    condition_word.lv |=> condition_word.lv)
    else $error("sticky overflow dropped without reset");

  a_lv_set: assert property (
    upd && res.ov_ev |=> condition_word.lv && condition_word.v)
    else $error("overflow did not set both overflow flags");

  a_uf_current: assert property (
    upd |=> condition_word.uf == $past(res.uf_ev && !is_absf))
    else $error("current underflow wrong after update");

  a_n_arith: assert property (
    upd && is_arith |=> condition_word.n == $past(res.neg))
    else $error("negative flag not the arithmetic sign");

  a_n_msb_sel: assert property (
    upd && is_bitwise |=> condition_word.n == $past(res.word[MSB]))
    else $error("negative flag not the output top bit");

  a_zero_flag: assert property (
    upd |=> condition_word.z == ($past(res.word) == WORD_ZERO))
    else $error("zero flag disagrees with the result");

  a_v_current: assert property (
    upd && !res.ov_ev |=> !condition_word.v)
    else $error("current overflow not cleared");

  a_carry_arith: assert property (
    upd && is_arith |=> condition_word.c == $past(res.carry))
    else $error("carry flag not the carry out");

  a_shift_zero_c: assert property (
    upd && is_shift && res.shift_zero |=> !condition_word.c)
    else $error("zero count shift left carry set");

  a_shift_last_c: assert property (
    upd && is_shift && !res.shift_zero
    |=> condition_word.c == $past(res.shift_out))
    else $error("carry not the last bit shifted out");

  a_hold_non_ext: assert property (
    res.valid && !dst_ext |=> $stable(condition_word))
    else $error("flags changed for a non extended register");

  a_sat_clamp: assert property (
    res.valid && sat_hit
    |=> dst_we && (dst_data == SAT_POS || dst_data == SAT_NEG)
    && dst_data[MSB] == $past(res.neg))
    else $error("saturated result not clamped to the right end");

  a_absf_clear: assert property (
    upd && is_absf |=> !condition_word.uf && !condition_word.n
    && $stable(condition_word.c) && $stable(condition_word.sticky_underflow))
    else $error("absolute value flag handling wrong");

  a_same_edge: assert property (
    upd |=> dst_we && dst_idx == $past(res.dst))
    else $error("flag update not paired with its write");

  // ----------------------------------------------------------------
  // per-flag and write-path checks
  // ----------------------------------------------------------------
  // each flag is checked on its own so a failure names the bit
  a_luf_hold: assert property (
    upd && !res.uf_ev |=> $stable(condition_word.sticky_underflow))
    else $error("sticky underflow changed without underflow");

  a_lv_hold: assert property (
    upd && !res.ov_ev |=> $stable(condition_word.lv))
    else $error("sticky overflow changed without overflow");

  a_lv_flt_ov: assert property (
    upd && is_flt && res.ov_ev |=> condition_word.lv)
    else $error("floating overflow did not set sticky overflow");

  a_lv_int_ov: assert property (
    upd && is_int && res.ov_ev |=> condition_word.lv && condition_word.v)
    else $error("integer overflow did not set the overflow flags");

  a_uf_set: assert property (
    upd && is_flt && res.uf_ev |=> condition_word.uf)
    else $error("current underflow not set by underflow");

  a_uf_clear: assert property (
    upd && !res.uf_ev |=> !condition_word.uf)
    else $error("current underflow not cleared");

  a_n_nonneg: assert property (
    upd && is_arith && !res.neg |=> !condition_word.n)
    else $error("negative flag set for a non negative result");

  a_n_logic: assert property (
    upd && is_logic |=> condition_word.n == $past(res.word[MSB]))
    else $error("logical result sign not taken from the top bit");

  a_z_arith: assert property (
    upd && is_arith |=> condition_word.z == ($past(res.word) == WORD_ZERO))
    else $error("zero flag wrong for an arithmetic result");

  a_z_bitwise: assert property (
    upd && is_bitwise
    |=> condition_word.z == ($past(res.word) == WORD_ZERO))
    else $error("zero flag wrong for a logical or shift output");

  a_v_set: assert property (
    upd && res.ov_ev |=> condition_word.v)
    else $error("current overflow not set by overflow");

  a_carry_set: assert property (
    upd && is_arith && res.carry |=> condition_word.c)
    else $error("carry flag not set by a carry");

  a_carry_logic: assert property (
    upd && is_logic |=> condition_word.c == $past(res.carry))
    else $error("carry flag wrong for a logical result");

  a_hold_no_class: assert property (
    res.valid && res.op == OP_NONE |=> $stable(condition_word))
    else $error("flags changed by a result with no flag class");

  // idle cycles sit between results except the final back-to-back pair, so this runs on every gap
  a_hold_idle: assert property (
    !res.valid |=> $stable(condition_word))
    else $error("flags changed with no result presented");

  a_sat_off_pass: assert property (
    res.valid && !saturate_select |=> dst_data == $past(res.word))
    else $error("result altered with saturation off");

  a_flt_no_clamp: assert property (
    res.valid && !is_int |=> dst_data == $past(res.word))
    else $error("non integer result altered by saturation");

  a_sat_pos: assert property (
    res.valid && saturate_select && is_int && res.ov_ev && !res.neg
    |=> dst_data == SAT_POS)
    else $error("positive overflow not clamped high");

  a_sat_neg: assert property (
    res.valid && saturate_select && is_int && res.ov_ev && res.neg
    |=> dst_data == SAT_NEG)
    else $error("negative overflow not clamped low");

  a_absf_rest: assert property (
    upd && is_absf |=> condition_word.v == $past(res.ov_ev)
    && condition_word.z == ($past(res.word) == WORD_ZERO))
    else $error("absolute value zero or overflow flag wrong");

  a_we_follows: assert property (
    1'b1 |=> dst_we == $past(res.valid))
    else $error("write strobe not one cycle after the result");

  a_idx_follows: assert property (
    res.valid |=> dst_idx == $past(res.dst))
    else $error("write index not the result destination");

  // reset itself is checked here, so the default disable is lifted
  a_reset_clear: assert property (
    @(posedge clk) disable iff (1'b0)
    srst |=> condition_word == FLAGS_RST && !dst_we)
    else $error("reset left flags or write strobe set");

  c_shift_out: cover property (upd && is_shift && res.shift_out);
  c_int_sat: cover property (sat_hit ##1 upd && !res.ov_ev);
  c_flt_uf: cover property (upd && is_flt && res.uf_ev);
  c_absf: cover property (upd && is_absf);
  c_non_ext: cover property (res.valid && !dst_ext);

endmodule

/* File: src/cfu_pkg.sv */
// shared types and constants for the condition flag update block
package cfu_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int RES_W = 32;
  localparam int DST_W = 5;
  localparam int NUM_EXT = 8;

  // ----------------------------------------------------------------
  // saturation words, used when the mode input asks for clamping
  // ----------------------------------------------------------------
  localparam logic [RES_W-1:0] SAT_POS = 32'h7fff_ffff;
  localparam logic [RES_W-1:0] SAT_NEG = 32'h8000_0000;
  localparam logic [RES_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam int MSB = RES_W - 1;

  // ----------------------------------------------------------------
  // operation classes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NONE  = 6'h01,
    OP_INT   = 6'h02,
    OP_FLT   = 6'h04,
    OP_LOGIC = 6'h08,
    OP_SHIFT = 6'h10,
    OP_ABSF  = 6'h20
  } cfu_op_e;

  // ----------------------------------------------------------------
  // condition word, order as listed by the assembler
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sticky_underflow;
    logic lv;
    logic uf;
    logic n;
    logic z;
    logic v;
    logic c;
  } cfu_flags_s;

  localparam cfu_flags_s FLAGS_RST = 7'h00;

  // ----------------------------------------------------------------
  // one result from the execution unit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [DST_W-1:0] dst;
    cfu_op_e op;
    logic [RES_W-1:0] word;
    logic uf_ev;
    logic ov_ev;
    logic carry;
    logic neg;
    logic shift_out;
    logic shift_zero;
  } cfu_res_s;

endpackage
